// [rtl/bscd_cfg.svh]
// Constants for the backplane strap configuration and decode block
// How it works
// - Off line disables all bus drivers, receivers
// - Off line holds firmware, interrupts still serviced
// - Off line darkens only the on-line indicator
// - Operator panel suspended whenever off line
// - Strap positions map to levels 1..22
// - Defer to requests on recognised higher levels
// - Never monitor own priority request line
// - Drive only the single generated level line
// - Four address straps give upper bits, MSB first
// - Main address 06..7E, low bits 110
// - Main at even base, realtime at odd
// - Eight consecutive channel addresses occupied
// - Panel strap inverted: absent means enabled
// - No interval selection means no counting
// - Interval ticks 76.8us halving to 600ns
// - Realtime clock 120/100, 60/50, external, or none
// - Address bit 0 zero, top bit 7 fixed at zero
`ifndef BSCD_CFG_SVH
`define BSCD_CFG_SVH

`define BSCD_CLK_MHZ 20
`define BSCD_LEVELS 22
`define BSCD_STRAP_BITS 24
`define BSCD_INTV_MIN_NS 600
`define BSCD_INTV_MIN_CYC ((`BSCD_INTV_MIN_NS * `BSCD_CLK_MHZ) / 1000)
`define BSCD_INTV_SEL 8

`define BSCD_MAIN_LOW 3'h6
`define BSCD_RTF_LOW 3'h7
`define BSCD_RSVD_LOW 3'h5
`define BSCD_CHDATA_LOW 3'h4

`define BSCD_REG_STATUS 8'h00
`define BSCD_REG_CHAN 8'h04
`define BSCD_REG_INTV 8'h08
`define BSCD_REG_RTC 8'h0c
`define BSCD_REG_CTRL 8'h10

`define BSCD_CTRL_RESET 3'h3
`define BSCD_CTRL_INTV_RUN 0
`define BSCD_CTRL_RTC_RUN 1
`define BSCD_CTRL_CLEAR 2

`define BSCD_RTC_LINE 0
`define BSCD_RTC_HALF 1
`define BSCD_RTC_EXT 2

`endif

// [rtl/bscd_pkg.sv]
// Types shared by the backplane strap decode block
package bscd_pkg;
    typedef enum logic [2:0] {
        BSCD_RTC_OFF_S = 3'b001,
        BSCD_RTC_FULL_S = 3'b010,
        BSCD_RTC_HALFED_S = 3'b100
    } bscd_rtc_type;
    typedef logic [4:0] bscd_level_type;
    typedef logic [7:0] bscd_chan_type;
endpackage

// [rtl/bscd_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bscd_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    // Stage one feeds stage two only; change accepted when two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_out <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
        end
    end
endmodule

// [rtl/bscd_tick.sv]
// Interval tick generator from a one-hot rate selection
`timescale 1ns/1ps
`include "bscd_cfg.svh"
module bscd_tick (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] rate_sel,
    output logic tick
);
    logic [10:0] pre_r;
    logic [10:0] period;
    logic none_sel;
    // Lowest selected position wins; a doubled jumper gives the slower rate
    function automatic logic [10:0] period_of(input logic [7:0] sel);
        logic [10:0] p;
        p = '0;
        for (int i = 7; i >= 0; i--) begin
            if (sel[i]) begin
                p = 11'(`BSCD_INTV_MIN_CYC << (7 - i));
            end
        end
        return p;
    endfunction
    assign period = period_of(rate_sel);
    assign none_sel = (rate_sel == 8'h00);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
            tick <= 1'b0;
        end else if (none_sel) begin
            pre_r <= '0;
            tick <= 1'b0;
        end else if (pre_r >= period - 11'h1) begin
            pre_r <= '0;
            tick <= 1'b1;
        end else begin
            pre_r <= pre_r + 11'h1;
            tick <= 1'b0;
        end
    end
endmodule

// [rtl/bscd_top.sv]
// Backplane attachment: on-line control, priority straps, channel decode, timers
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "bscd_cfg.svh"
module bscd_top
    import bscd_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic offline_switch,
    input wire logic [7:0] priority_recognition_strap_a,
    input wire logic [7:0] priority_recognition_strap_b,
    input wire logic [7:0] priority_recognition_strap_c,
    input wire logic [7:0] priority_generation_strap_a,
    input wire logic [7:0] priority_generation_strap_b,
    input wire logic [7:0] priority_generation_strap_c,
    input wire logic [6:0] channel_address_strap,
    input wire logic [7:0] interval_rate_strap,
    input wire logic [3:0] rtc_rate_strap,
    input wire logic line_freq_clk,
    input wire logic rtc_ext_clk,
    input wire logic [21:0] bus_prio_req_in,
    output logic [21:0] bus_prio_req_out,
    output logic [21:0] bus_prio_req_oe_n,
    output logic bus_rx_enable_n,
    output logic bus_tx_enable_n,
    input wire logic dev_bus_req,
    output logic bus_grant,
    input wire logic bus_addr_valid,
    input wire logic [7:0] bus_addr,
    output logic main_port_hit,
    output logic realtime_function_port_hit,
    output logic data_port_hit,
    output logic [2:0] port_select,
    input wire logic fw_new_op_req,
    input wire logic fw_micro_irq,
    output logic fw_hold,
    output logic fw_start,
    output logic fw_irq_ack,
    input wire logic chan_init_done,
    input wire logic class_f_irq_pending,
    input wire logic realtime_irq_active,
    output logic online_indicator,
    output logic channel_init_indicator,
    output logic pending_interrupt_indicator,
    output logic realtime_request_indicator,
    input wire logic panel_req,
    output logic panel_active,
    output logic intv_tick_out,
    output logic rtc_tick_out,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    logic rst_a_r;
    logic rst_n_r;
    logic [69:0] pins_s;
    logic offline_s;
    logic line_s;
    logic ext_s;
    logic [23:0] recog_r;
    logic [23:0] gen_r;
    logic [6:0] chan_strap_r;
    logic [7:0] intv_strap_r;
    logic [3:0] rtc_strap_r;
    logic online_r;
    logic line_d_r;
    logic ext_d_r;
    logic [2:0] ctrl_r;
    logic [15:0] intv_count_r;
    logic [15:0] rtc_count_r;
    logic intv_tick;
    bscd_rtc_type rtc_state_r;
    bscd_rtc_type rtc_state_nxt;

    // Reset released through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_n_r <= rst_a_r;
        end
    end

    // Switch enters as on-line level, so a cleared sync flop means off line after reset
    bscd_sync #(.W(70)) u_sync (
        .clk(clk),
        .rst_n(rst_n_r),
        .pin_in({!offline_switch, line_freq_clk, rtc_ext_clk,
                 priority_recognition_strap_c, priority_recognition_strap_b, priority_recognition_strap_a,
                 priority_generation_strap_c, priority_generation_strap_b, priority_generation_strap_a,
                 channel_address_strap, interval_rate_strap, rtc_rate_strap}),
        .level_out(pins_s)
    );

    assign offline_s = !pins_s[69];
    assign line_s = pins_s[68];
    assign ext_s = pins_s[67];

    // Straps are frozen while on line so a bumped jumper cannot move the card
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            recog_r <= '0;
            gen_r <= '0;
            chan_strap_r <= '0;
            intv_strap_r <= '0;
            rtc_strap_r <= '0;
        end else if (!online_r) begin
            recog_r <= pins_s[66:43];
            gen_r <= pins_s[42:19];
            chan_strap_r <= pins_s[18:12];
            intv_strap_r <= pins_s[11:4];
            rtc_strap_r <= pins_s[3:0];
        end
    end

    // Position to level: generation X?-1 of header a is level 1
    function automatic bscd_level_type level_of(input logic [23:0] g);
        bscd_level_type l;
        l = '0;
        for (int i = `BSCD_LEVELS - 1; i >= 0; i--) begin
            if (g[i]) begin
                l = 5'(i + 1);
            end
        end
        return l;
    endfunction

    wire bscd_level_type own_level = level_of(gen_r);
    wire [21:0] own_mask = gen_r[21:0];
    wire [21:0] recog_mask = recog_r[22:1] & ~own_mask;
    wire higher_busy = |(bus_prio_req_in & recog_mask);
    wire own_valid = (own_level != 5'h00) && $onehot(gen_r[21:0]);
    wire want_bus = online_r && dev_bus_req && own_valid;

    wire panel_en = !chan_strap_r[0];
    wire bscd_chan_type chan_base = {1'b0, chan_strap_r[1], chan_strap_r[2], chan_strap_r[3], chan_strap_r[4],
                                     3'h0};
    wire bscd_chan_type main_addr = chan_base | {5'h00, `BSCD_MAIN_LOW};
    wire bscd_chan_type rtf_addr = chan_base | {5'h00, `BSCD_RTF_LOW};
    wire in_block = bus_addr_valid && (bus_addr[7:3] == chan_base[7:3]);
    wire is_data = in_block && (bus_addr[2:0] <= `BSCD_CHDATA_LOW);

    // On-line state, bus enables, arbitration and firmware gating
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            online_r <= 1'b0;
            bus_rx_enable_n <= 1'b1;
            bus_tx_enable_n <= 1'b1;
            bus_prio_req_out <= '0;
            bus_prio_req_oe_n <= '1;
            bus_grant <= 1'b0;
            fw_hold <= 1'b1;
            fw_start <= 1'b0;
            fw_irq_ack <= 1'b0;
        end else begin
            online_r <= !offline_s;
            bus_rx_enable_n <= !online_r;
            bus_tx_enable_n <= !online_r;
            bus_prio_req_out <= '0;
            bus_prio_req_oe_n <= want_bus ? ~own_mask : '1;
            bus_grant <= want_bus && !higher_busy;
            fw_hold <= !online_r;
            fw_start <= online_r && fw_new_op_req;
            fw_irq_ack <= fw_micro_irq;
        end
    end

    // Channel address decode, nothing seen while detached
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            main_port_hit <= 1'b0;
            realtime_function_port_hit <= 1'b0;
            data_port_hit <= 1'b0;
            port_select <= '0;
        end else begin
            main_port_hit <= online_r && bus_addr_valid && bus_addr == main_addr;
            realtime_function_port_hit <= online_r && bus_addr_valid && bus_addr == rtf_addr;
            data_port_hit <= online_r && is_data;
            port_select <= (online_r && in_block) ? bus_addr[2:0] : 3'h0;
        end
    end

    // Indicators and panel
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            online_indicator <= 1'b0;
            channel_init_indicator <= 1'b0;
            pending_interrupt_indicator <= 1'b0;
            realtime_request_indicator <= 1'b0;
            panel_active <= 1'b0;
        end else begin
            online_indicator <= online_r;
            channel_init_indicator <= chan_init_done;
            pending_interrupt_indicator <= class_f_irq_pending;
            realtime_request_indicator <= realtime_irq_active;
            panel_active <= online_r && panel_en && panel_req;
        end
    end

    bscd_tick u_tick (
        .clk(clk),
        .rst_n(rst_n_r),
        .rate_sel(intv_strap_r),
        .tick(intv_tick)
    );

    // Real-time clock source: edges of line or external clock, halved for 60/50
    wire line_rise = line_s && !line_d_r;
    wire ext_rise = ext_s && !ext_d_r;
    wire rtc_src_edge = rtc_strap_r[`BSCD_RTC_EXT] ? ext_rise : line_rise;
    wire rtc_none = !(|rtc_strap_r[2:0]);

    always_comb begin
        rtc_state_nxt = rtc_state_r;
        case (rtc_state_r)
            BSCD_RTC_OFF_S: begin
                if (!rtc_none) begin
                    rtc_state_nxt = BSCD_RTC_FULL_S;
                end
            end
            BSCD_RTC_FULL_S: begin
                if (rtc_none) begin
                    rtc_state_nxt = BSCD_RTC_OFF_S;
                end else if (rtc_src_edge && rtc_strap_r[`BSCD_RTC_HALF] && !rtc_strap_r[`BSCD_RTC_LINE]) begin
                    rtc_state_nxt = BSCD_RTC_HALFED_S;
                end
            end
            BSCD_RTC_HALFED_S: begin
                if (rtc_none) begin
                    rtc_state_nxt = BSCD_RTC_OFF_S;
                end else if (rtc_src_edge) begin
                    rtc_state_nxt = BSCD_RTC_FULL_S;
                end
            end
            default: begin
                rtc_state_nxt = BSCD_RTC_OFF_S;
            end
        endcase
    end

    wire half_mode = rtc_strap_r[`BSCD_RTC_HALF] && !rtc_strap_r[`BSCD_RTC_LINE] && !rtc_strap_r[`BSCD_RTC_EXT];
    wire rtc_tick = rtc_src_edge && !rtc_none && (!half_mode || rtc_state_r == BSCD_RTC_HALFED_S);
    wire clr_wr = reg_wr && (reg_addr == `BSCD_REG_CTRL) && reg_wdata[`BSCD_CTRL_CLEAR];

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            line_d_r <= 1'b0;
            ext_d_r <= 1'b0;
            rtc_state_r <= BSCD_RTC_OFF_S;
            intv_count_r <= '0;
            rtc_count_r <= '0;
            intv_tick_out <= 1'b0;
            rtc_tick_out <= 1'b0;
        end else begin
            line_d_r <= line_s;
            ext_d_r <= ext_s;
            rtc_state_r <= rtc_state_nxt;
            intv_tick_out <= intv_tick && ctrl_r[`BSCD_CTRL_INTV_RUN];
            rtc_tick_out <= rtc_tick && ctrl_r[`BSCD_CTRL_RTC_RUN];
            if (clr_wr) begin
                intv_count_r <= '0;
                rtc_count_r <= '0;
            end else begin
                if (intv_tick && ctrl_r[`BSCD_CTRL_INTV_RUN]) begin
                    intv_count_r <= intv_count_r + 16'h1;
                end
                if (rtc_tick && ctrl_r[`BSCD_CTRL_RTC_RUN]) begin
                    rtc_count_r <= rtc_count_r + 16'h1;
                end
            end
        end
    end

    // Register port: one-cycle read data, unmapped reads give zero
    wire [31:0] status_word = {12'h000, rtc_strap_r, intv_strap_r == 8'h00, panel_en, online_r,
                               own_level, 3'h0, own_valid, main_addr[6:3]};
    wire [31:0] chan_word = {8'h00, rtf_addr, main_addr, chan_base};
    wire [31:0] read_mux = (reg_addr == `BSCD_REG_STATUS) ? status_word :
                           (reg_addr == `BSCD_REG_CHAN) ? chan_word :
                           (reg_addr == `BSCD_REG_INTV) ? {16'h0000, intv_count_r} :
                           (reg_addr == `BSCD_REG_RTC) ? {16'h0000, rtc_count_r} :
                           (reg_addr == `BSCD_REG_CTRL) ? {29'h00000000, ctrl_r} : 32'h00000000;

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= `BSCD_CTRL_RESET;
            reg_rdata <= '0;
        end else begin
            if (reg_wr && reg_addr == `BSCD_REG_CTRL) begin
                ctrl_r <= {1'b0, reg_wdata[1:0]};
            end
            reg_rdata <= reg_rd ? read_mux : 32'h00000000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_r);

    sequence s_detach;
        !online_r ##1 !online_r;
    endsequence
    sequence s_win;
        want_bus && !higher_busy;
    endsequence

    a_offline_detach: assert property (s_detach |-> bus_rx_enable_n && bus_tx_enable_n && (&bus_prio_req_oe_n))
        else $error("bus not detached while off line");
    a_hold_no_start: assert property (s_detach |-> fw_hold && !fw_start)
        else $error("firmware started while off line");
    a_irq_served: assert property (fw_micro_irq |=> fw_irq_ack)
        else $error("micro interrupt not serviced");
    a_led_online_off: assert property (!online_r |=> !online_indicator ##0 (channel_init_indicator == $past(chan_init_done)))
        else $error("indicators wrong while off line");
    a_panel_gated: assert property (panel_active |-> $past(online_r) && $past(panel_en))
        else $error("panel active while off line or disabled");
    a_defer_higher: assert property (higher_busy |=> !bus_grant)
        else $error("granted over higher priority request");
    a_own_ignored: assert property ((bus_prio_req_in & ~own_mask) == 22'h000000 && want_bus |=> bus_grant)
        else $error("own level line blocked the grant");
    a_win_drive: assert property (s_win |=> bus_grant && ((~bus_prio_req_oe_n) == $past(own_mask)))
        else $error("wrong request line driven");
    a_one_line: assert property ($onehot0(~bus_prio_req_oe_n))
        else $error("more than one request line driven");
    a_main_rtf: assert property (online_r && bus_addr_valid && bus_addr == main_addr
        |=> main_port_hit && !realtime_function_port_hit ##0 port_select == 3'h6)
        else $error("main port decode wrong");
    a_addr_form: assert property (main_addr[2:0] == 3'h6 && !main_addr[7] && !chan_base[0])
        else $error("channel address form wrong");
    a_intv_still: assert property (intv_strap_r == 8'h00 ##1 intv_strap_r == 8'h00 && !clr_wr |=> $stable(intv_count_r))
        else $error("interval timer counted with no rate");
    a_rtc_none: assert property (rtc_none |=> !rtc_tick_out)
        else $error("real-time clock ticked with no rate");
endmodule

// [testbench/bscd_bus_model.sv]
// Backplane model: other cards' priority requests on the shared request lines
`timescale 1ns/1ps
module bscd_bus_model #(
    parameter int OWN_LEVEL = 9
) (
    input wire logic clk,
    input wire logic [21:0] other_req,
    input wire logic [21:0] dut_oe_n,
    output logic [21:0] lines
);
    logic [21:0] others_r;
    // Other cards change after the edge and never claim the device's level
    always_ff @(posedge clk) begin
        others_r <= other_req & ~(22'h1 << (OWN_LEVEL - 1));
    end
    // Wired request lines, so the device sees its own request too
    assign lines = others_r | ~dut_oe_n;
endmodule

// [testbench/backplane_strap_config_decode_tb.sv]
// Self-checking bench for the backplane strap configuration and decode block
`timescale 1ns/1ps
module backplane_strap_config_decode_tb;
    import bscd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic off_sw = 1'b1;
    logic [7:0] rec_a = 8'hfe;
    logic [7:0] gen_b = 8'h01;
    logic [6:0] chan = 7'h02;
    logic [7:0] intv = 8'h80;
    logic [3:0] rtc = 4'h1;
    logic line_clk = 1'b0, ext_clk = 1'b0, dev_req = 1'b0, av = 1'b0, new_op = 1'b0, irq = 1'b0;
    logic ci = 1'b0, pi = 1'b0, rr = 1'b0, preq = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, raddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [21:0] other = 22'h0;
    logic [21:0] lines, pout, oe_n;
    logic [2:0] psel;
    logic [31:0] rdata;
    logic rx_n, tx_n, grant, mhit, rhit, dhit, hold, start, ack, on_ind, ci_o, pi_o, rr_o, pact, itick, rtick;
    int mismatches = 0;
    int tests_run = 0;
    int rt_count = 0;

    bscd_top DUT (
        .clk(clk), .reset_n(reset_n), .offline_switch(off_sw),
        .priority_recognition_strap_a(rec_a), .priority_recognition_strap_b(8'h01),
        .priority_recognition_strap_c(8'h00), .priority_generation_strap_a(8'h00),
        .priority_generation_strap_b(gen_b), .priority_generation_strap_c(8'h00),
        .channel_address_strap(chan), .interval_rate_strap(intv), .rtc_rate_strap(rtc),
        .line_freq_clk(line_clk), .rtc_ext_clk(ext_clk), .bus_prio_req_in(lines),
        .bus_prio_req_out(pout), .bus_prio_req_oe_n(oe_n), .bus_rx_enable_n(rx_n), .bus_tx_enable_n(tx_n),
        .dev_bus_req(dev_req), .bus_grant(grant), .bus_addr_valid(av), .bus_addr(addr),
        .main_port_hit(mhit), .realtime_function_port_hit(rhit), .data_port_hit(dhit), .port_select(psel),
        .fw_new_op_req(new_op), .fw_micro_irq(irq), .fw_hold(hold), .fw_start(start), .fw_irq_ack(ack),
        .chan_init_done(ci), .class_f_irq_pending(pi), .realtime_irq_active(rr),
        .online_indicator(on_ind), .channel_init_indicator(ci_o), .pending_interrupt_indicator(pi_o),
        .realtime_request_indicator(rr_o), .panel_req(preq), .panel_active(pact),
        .intv_tick_out(itick), .rtc_tick_out(rtick), .reg_addr(raddr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata)
    );
    bscd_bus_model #(.OWN_LEVEL(9)) bus (.clk(clk), .other_req(other), .dut_oe_n(oe_n), .lines(lines));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (rtick === 1'b1) begin
            rt_count <= rt_count + 1;
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        raddr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        raddr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Bus quiet before every change of state, bounded wait for the indicator
    task automatic set_line(input logic off);
        @(posedge clk);
        other <= 22'h0;
        off_sw <= off;
        for (int i = 0; i < 30 && on_ind !== !off; i++) begin
            @(negedge clk);
        end
        if (on_ind !== !off) begin
            mismatches++;
            final_report();
        end
        repeat (3) @(posedge clk);
    endtask
    // Straps only latch while off line
    task automatic cfg(input logic [6:0] c, input logic [7:0] iv, input logic [3:0] r, input logic [7:0] g);
        set_line(1'b1);
        chan <= c;
        intv <= iv;
        rtc <= r;
        gen_b <= g;
        repeat (8) @(posedge clk);
        set_line(1'b0);
    endtask
    function automatic logic [31:0] status_exp;
        return {12'h0, rtc, intv == 8'h00, ~chan[0], 1'b1, 5'h09, 3'h0, 1'b1, chan[1], chan[2], chan[3], chan[4]};
    endfunction

    task automatic t_offline;
        @(posedge clk);
        {dev_req, new_op, irq, preq, ci, pi, rr} <= 7'h7d;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("detach", {rx_n, tx_n, oe_n, grant}, 25'h1fffffe);
        check("fw off", {hold, start, ack}, 3'h5);
        check("ind off", {on_ind, ci_o, pi_o, rr_o}, 4'h5);
        check("panel off", pact, 1'b0);
        set_line(1'b0);
        {ci, pi, rr} <= 3'h2;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("attach", {rx_n, tx_n}, 2'h0);
        check("fw on", {hold, start, ack}, 3'h3);
        check("ind on", {on_ind, ci_o, pi_o, rr_o}, 4'ha);
        check("panel on", pact, 1'b1);
    endtask
    task automatic t_arb;
        logic [21:0] reqs [6] = '{22'h0, 22'h1, 22'h80, 22'h100, 22'h200, 22'h200000};
        logic [7:0] bad [2] = '{8'h03, 8'h00};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            other <= reqs[i];
            repeat (4) @(posedge clk);
            @(negedge clk);
            check("grant", grant, reqs[i][7:0] == 8'h00);
            check("own line", {oe_n, pout}, {22'h3ffeff, 22'h0});
        end
        for (int i = 0; i < 2; i++) begin
            cfg(7'h02, 8'h80, 4'h1, bad[i]);
            repeat (4) @(posedge clk);
            @(negedge clk);
            check("bad level", {oe_n, grant}, 23'h7ffffe);
        end
        cfg(7'h02, 8'h80, 4'h1, 8'h01);
    endtask
    task automatic t_regs;
        logic [31:0] d;
        reg_read(8'h20, d);
        check("unmapped", d, 32'h0);
        reg_write(8'h20, 32'hffffffff);
        reg_write(8'h04, 32'h0);
        reg_read(8'h10, d);
        check("ctrl", d, 32'h3);
        @(posedge clk);
        chan <= 7'h00;
        repeat (8) @(posedge clk);
        reg_read(8'h04, d);
        check("chan frozen", d, 32'h00474640);
    endtask
    task automatic t_decode;
        logic [6:0] straps [2] = '{7'h02, 7'h1f};
        logic [7:0] base;
        logic [31:0] d;
        for (int s = 0; s < 2; s++) begin
            cfg(straps[s], 8'h80, 4'h1, 8'h01);
            base = {1'b0, straps[s][1], straps[s][2], straps[s][3], straps[s][4], 3'h0};
            // Each address from just below to just above the block
            for (int k = -1; k < 9; k++) begin
                @(posedge clk);
                av <= 1'b1;
                addr <= base + 8'(k);
                @(posedge clk);
                av <= 1'b0;
                @(negedge clk);
                check("decode", {mhit, rhit, dhit, psel}, (k < 0 || k > 7) ? 6'h0 :
                    {k == 6, k == 7, k < 5, 3'(k)});
            end
            check("panel strap", pact, !straps[s][0]);
            reg_read(8'h00, d);
            check("status", d, status_exp());
            reg_read(8'h04, d);
            check("chan", d, {8'h0, base + 8'h07, base + 8'h06, base});
        end
    endtask
    task automatic t_timers;
        int n;
        logic [31:0] d;
        logic [3:0] modes [4] = '{4'h1, 4'h2, 4'h4, 4'h0};
        int rt_exp [4] = '{4, 2, 4, 0};
        for (int i = 0; i < 9; i++) begin
            cfg(7'h02, i < 8 ? 8'h01 << i : 8'h00, 4'h1, 8'h01);
            // First wait finds a tick, second measures the gap to the next
            for (int w = 0; w < 2; w++) begin
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (itick !== 1'b1 && n < 2000);
            end
            check("tick period", n, i < 8 ? 12 << (7 - i) : 2000);
        end
        for (int m = 0; m < 4; m++) begin
            cfg(7'h02, 8'h80, modes[m], 8'h01);
            @(negedge clk);
            rt_count = 0;
            for (int e = 0; e < 8; e++) begin
                @(posedge clk);
                if (e < 4)
                    line_clk <= 1'b1;
                else
                    ext_clk <= 1'b1;
                repeat (10) @(posedge clk);
                line_clk <= 1'b0;
                ext_clk <= 1'b0;
                repeat (10) @(posedge clk);
            end
            check("rtc ticks", rt_count, rt_exp[m]);
        end
        // Count register holds every tick of the four modes
        reg_read(8'h0c, d);
        check("rtc count", d, 32'h0000000a);
        reg_write(8'h10, 32'h00000004);
        reg_read(8'h08, d);
        check("intv cleared", d, 32'h00000000);
        reg_read(8'h10, d);
        check("ctrl stopped", d, 32'h00000000);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        check("reset drives", {oe_n, rx_n, tx_n, hold}, 25'h1ffffff);
        check("reset outputs", {grant, on_ind, mhit, itick, pact}, 5'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_offline();
        t_arb();
        t_regs();
        t_decode();
        t_timers();
        final_report();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
